// ---- hdl/tpl_touch_probe.sv ----
// two-channel position capture unit with dictionary object port
// assumes dictionary accesses are single-cycle strobes synchronous to clk_sys
//
// How it works
// - status bit 0 is high while channel one is switched on
// - status bit 1 shows channel one rising capture completed
// - status bit 2 shows channel one falling capture completed
// - channel two reports at status bits 8, 9 and 10
// - status bits 3-7 and 11-15 read as zero
// - channel one rising and falling positions latch into separate registers
// - channel two rising and falling positions latch into two more registers
// - four continuous-mode counters, one per channel and edge
// - enable rising edge samples mode and edge selects, then arms
// - single mode captures once; re-toggling enable re-arms
// - continuous mode captures every trigger, latch keeps the latest
// - mode bit 0 means single, 1 means continuous
// - input status bits 26 and 27 flag channel triggers
// - control bits 0/8 enable, 1/9 mode, 4/12 rise, 5/13 fall
// - both pins on one channel: coincident edges count once
`include "tpl_defs.svh"
module tpl_touch_probe #(
    parameter int POS_W = 32,
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // probe pins
    input  wire logic             first_digital_input,
    input  wire logic             second_digital_input,
    // current position count
    input  wire logic [POS_W-1:0] position,
    // dictionary object port
    input  wire logic             obj_wr,
    input  wire logic             obj_rd,
    input  wire logic [15:0]      obj_index,
    input  wire logic [7:0]       obj_sub,
    input  wire logic [31:0]      obj_wdata,
    output logic [31:0]           obj_rdata,
    output logic                  obj_ack,
    output logic                  obj_err
);
    logic [15:0]      control_q;
    logic [15:0]      func_one_q;
    logic [15:0]      func_two_q;
    logic [1:0]       pin_rise;
    logic [1:0]       pin_fall;
    logic [1:0]       ch_rise;
    logic [1:0]       ch_fall;
    logic [1:0]       active;
    logic [1:0]       rise_done;
    logic [1:0]       fall_done;
    logic [1:0]       trig_flag;
    logic [POS_W-1:0] rise_pos [2];
    logic [POS_W-1:0] fall_pos [2];
    logic [CNT_W-1:0] rise_cnt [2];
    logic [CNT_W-1:0] fall_cnt [2];
    logic [15:0]      status_word;
    logic [31:0]      input_word;
    logic [31:0]      rd_d;
    logic             hit;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    tpl_edge_sync u_sync_one (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin_in  (first_digital_input),
        .rise    (pin_rise[0]),
        .fall    (pin_fall[0])
    );
    tpl_edge_sync u_sync_two (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin_in  (second_digital_input),
        .rise    (pin_rise[1]),
        .fall    (pin_fall[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // routing: an OR merges both pins, so coincident edges give one event
    always_comb begin
        ch_rise = 2'b00;
        ch_fall = 2'b00;
        if (func_one_q == `TPL_FUNC_CH_ONE) begin
            ch_rise[0] = ch_rise[0] | pin_rise[0];
            ch_fall[0] = ch_fall[0] | pin_fall[0];
        end
        if (func_one_q == `TPL_FUNC_CH_TWO) begin
            ch_rise[1] = ch_rise[1] | pin_rise[0];
            ch_fall[1] = ch_fall[1] | pin_fall[0];
        end
        if (func_two_q == `TPL_FUNC_CH_ONE) begin
            ch_rise[0] = ch_rise[0] | pin_rise[1];
            ch_fall[0] = ch_fall[0] | pin_fall[1];
        end
        if (func_two_q == `TPL_FUNC_CH_TWO) begin
            ch_rise[1] = ch_rise[1] | pin_rise[1];
            ch_fall[1] = ch_fall[1] | pin_fall[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels
    for (genvar c = 0; c < 2; c++) begin : g_ch
        tpl_channel #(
            .POS_W (POS_W),
            .CNT_W (CNT_W)
        ) u_ch (
            .clk_sys   (clk_sys),
            .resetn    (resetn),
            .ctl       (control_q[c*`TPL_CH_STRIDE +: 8]),
            .rise      (ch_rise[c]),
            .fall      (ch_fall[c]),
            .position  (position),
            .active    (active[c]),
            .rise_done (rise_done[c]),
            .fall_done (fall_done[c]),
            .trig_flag (trig_flag[c]),
            .rise_pos  (rise_pos[c]),
            .fall_pos  (fall_pos[c]),
            .rise_cnt  (rise_cnt[c]),
            .fall_cnt  (fall_cnt[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable objects; the master must re-toggle enable to apply mode and edge edits, pin function edits apply at once
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            control_q  <= `TPL_RST_CONTROL;
            func_one_q <= `TPL_RST_FUNC_ONE;
            func_two_q <= `TPL_RST_FUNC_TWO;
        end else if (obj_wr) begin
            if (obj_index == `TPL_IDX_CONTROL) begin
                control_q <= obj_wdata[15:0];
            end
            if (obj_index == `TPL_IDX_PIN_FUNC_ONE && obj_sub == 8'h01) begin
                func_one_q <= obj_wdata[15:0];
            end
            if (obj_index == `TPL_IDX_PIN_FUNC_ONE && obj_sub == 8'h02) begin
                func_two_q <= obj_wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read side
    always_comb begin
        status_word = 16'h0000;
        status_word[`TPL_ST_ACTIVE]    = active[0];
        status_word[`TPL_ST_RISE_DONE] = rise_done[0];
        status_word[`TPL_ST_FALL_DONE] = fall_done[0];
        status_word[`TPL_CH_STRIDE + `TPL_ST_ACTIVE]    = active[1];
        status_word[`TPL_CH_STRIDE + `TPL_ST_RISE_DONE] = rise_done[1];
        status_word[`TPL_CH_STRIDE + `TPL_ST_FALL_DONE] = fall_done[1];
        input_word = 32'h0000_0000;
        input_word[`TPL_IN_TRIG_ONE +: 2] = trig_flag;
        input_word[1:0] = {second_digital_input, first_digital_input};
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        hit  = 1'b1;
        case (obj_index)
            `TPL_IDX_CONTROL:      rd_d = {16'h0000, control_q};
            `TPL_IDX_STATUS:       rd_d = {16'h0000, status_word};
            `TPL_IDX_ONE_RISE_POS: rd_d = 32'(rise_pos[0]);
            `TPL_IDX_ONE_FALL_POS: rd_d = 32'(fall_pos[0]);
            `TPL_IDX_TWO_RISE_POS: rd_d = 32'(rise_pos[1]);
            `TPL_IDX_TWO_FALL_POS: rd_d = 32'(fall_pos[1]);
            `TPL_IDX_ONE_RISE_CNT: rd_d = 32'(rise_cnt[0]);
            `TPL_IDX_ONE_FALL_CNT: rd_d = 32'(fall_cnt[0]);
            `TPL_IDX_TWO_RISE_CNT: rd_d = 32'(rise_cnt[1]);
            `TPL_IDX_TWO_FALL_CNT: rd_d = 32'(fall_cnt[1]);
            `TPL_IDX_INPUT_STATUS: rd_d = input_word;
            `TPL_IDX_PIN_FUNC_ONE: rd_d = {16'h0000, (obj_sub == 8'h02) ? func_two_q : func_one_q};
            default:               hit  = 1'b0;
        endcase
    end

    // read data registered; unknown indexes answer with an error pulse and zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            obj_ack <= 1'b0;
        end else begin
            obj_ack <= obj_rd | obj_wr;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            obj_err <= 1'b0;
        end else begin
            obj_err <= (obj_rd | obj_wr) & ~hit;
        end
    end

    // zero outside a read keeps stale data off the port
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            obj_rdata <= 32'h0000_0000;
        end else begin
            obj_rdata <= (obj_rd & hit) ? rd_d : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on what this block drives
    default clocking chk_cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    AST_RESERVED: assert property (
        (status_word[7:3] == 5'h00)
        && (status_word[15:11] == 5'h00))
        else $error("reserved status bits set");

    AST_TRIG_STATUS: assert property (
        trig_flag[1]
        |-> active[1] || !control_q[`TPL_CH_STRIDE] || !$past(control_q[`TPL_CH_STRIDE]))
        else $error("channel two flag without activity");

    AST_DONE_IN_STATUS: assert property (
        (obj_rd && obj_index == `TPL_IDX_STATUS)
        |=> obj_rdata[9] == $past(rise_done[1]))
        else $error("status read mismatch");

    AST_ACTIVE_ON: assert property (
        $rose(control_q[`TPL_CTL_ENABLE])
        |=> active[0])
        else $error("channel one not active");

    AST_ACTIVE_OFF: assert property (
        !control_q[`TPL_CTL_ENABLE]
        |=> !active[0])
        else $error("channel one still active");

    AST_RISE_CAUSE: assert property (
        $rose(rise_done[0])
        |-> $past(ch_rise[0]))
        else $error("rise done without edge");

    AST_FALL_CAUSE: assert property (
        $rose(fall_done[0])
        |-> $past(ch_fall[0]))
        else $error("fall done without edge");

    AST_STATUS_ONE: assert property (
        (obj_rd && obj_index == `TPL_IDX_STATUS)
        |=> obj_rdata[`TPL_ST_FALL_DONE] == $past(fall_done[0]))
        else $error("fall done bit misplaced");

    AST_ACTIVE_TWO: assert property (
        !control_q[`TPL_CH_STRIDE]
        |=> !active[1])
        else $error("channel two still active");

    AST_POS_READ: assert property (
        (obj_rd && obj_index == `TPL_IDX_ONE_RISE_POS)
        |=> obj_rdata[POS_W-1:0] == $past(rise_pos[0]))
        else $error("rise latch read wrong");

    AST_POS_TWO_READ: assert property (
        (obj_rd && obj_index == `TPL_IDX_TWO_FALL_POS)
        |=> obj_rdata[POS_W-1:0] == $past(fall_pos[1]))
        else $error("fall latch read wrong");

    AST_CNT_READ: assert property (
        (obj_rd && obj_index == `TPL_IDX_TWO_FALL_CNT)
        |=> obj_rdata[CNT_W-1:0] == $past(fall_cnt[1]))
        else $error("counter read wrong");

    AST_CTL_WRITE: assert property (
        (obj_wr && obj_index == `TPL_IDX_CONTROL)
        |=> control_q == $past(obj_wdata[15:0]))
        else $error("control write lost");

    AST_TRIG_CAUSE: assert property (
        $rose(trig_flag[0])
        |-> $past(ch_rise[0]) || $past(ch_fall[0]))
        else $error("flag without edge");

    AST_TRIG_READ: assert property (
        (obj_rd && obj_index == `TPL_IDX_INPUT_STATUS)
        |=> obj_rdata[`TPL_IN_TRIG_ONE +: 2] == $past(trig_flag))
        else $error("trigger flags read wrong");

    AST_ROUTE_NONE: assert property (
        (func_one_q != `TPL_FUNC_CH_ONE && func_two_q != `TPL_FUNC_CH_ONE)
        |-> !ch_rise[0] && !ch_fall[0])
        else $error("unrouted edge reached channel");

    AST_ROUTE_MERGE: assert property (
        (func_one_q == `TPL_FUNC_CH_ONE && func_two_q == `TPL_FUNC_CH_ONE)
        |-> ch_rise[0] == (pin_rise[0] || pin_rise[1]))
        else $error("merged edges wrong");

    AST_IDLE_TWO: assert property (
        !control_q[`TPL_CH_STRIDE]
        |=> $stable(rise_pos[1]) && $stable(fall_cnt[1]))
        else $error("disabled channel two changed");
endmodule

// ---- hdl/tpl_defs.svh ----
// constants of the position capture unit: object indexes, field positions, reset values
// assumes nothing beyond being included by its bare name
`ifndef TPL_DEFS_SVH
`define TPL_DEFS_SVH
// object indexes on the dictionary port
`define TPL_IDX_CONTROL      16'h60b8
`define TPL_IDX_STATUS       16'h60b9
`define TPL_IDX_ONE_RISE_POS 16'h60ba
`define TPL_IDX_ONE_FALL_POS 16'h60bb
`define TPL_IDX_TWO_RISE_POS 16'h60bc
`define TPL_IDX_TWO_FALL_POS 16'h60bd
`define TPL_IDX_ONE_RISE_CNT 16'h60d5
`define TPL_IDX_ONE_FALL_CNT 16'h60d6
`define TPL_IDX_TWO_RISE_CNT 16'h60d7
`define TPL_IDX_TWO_FALL_CNT 16'h60d8
`define TPL_IDX_INPUT_STATUS 16'h60fd
`define TPL_IDX_PIN_FUNC_ONE 16'h2152
// control byte fields, per channel, channel two is offset by eight
`define TPL_CTL_ENABLE       0
`define TPL_CTL_MODE         1
`define TPL_CTL_RISE         4
`define TPL_CTL_FALL         5
`define TPL_CH_STRIDE        8
// status word fields
`define TPL_ST_ACTIVE        0
`define TPL_ST_RISE_DONE     1
`define TPL_ST_FALL_DONE     2
// trigger flags in the input status word
`define TPL_IN_TRIG_ONE      26
// pin function codes
`define TPL_FUNC_CH_ONE      16'h0020
`define TPL_FUNC_CH_TWO      16'h0040
// reset values
`define TPL_RST_CONTROL      16'h0000
`define TPL_RST_FUNC_ONE     16'h0001
`define TPL_RST_FUNC_TWO     16'h0002
`endif

// ---- hdl/tpl_pkg.sv ----
// types of the position capture unit
// assumes the constants header is compiled alongside
package tpl_pkg;
    typedef enum logic {
        TPL_SINGLE,
        TPL_CONTINUOUS
    } tpl_mode_t;
    typedef enum {
        TPL_IDLE,
        TPL_ARMED,
        TPL_SPENT
    } tpl_state_t;
endpackage

// ---- hdl/tpl_edge_sync.sv ----
// two-stage synchroniser and edge detector for one probe pin
// assumes the pin is asynchronous to clk_sys
module tpl_edge_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // pin
    input  wire logic pin_in,
    // edges on the synchronised level
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule

// ---- hdl/tpl_channel.sv ----
// one capture channel: arming, single or continuous latch, counters
// assumes edges are one-cycle pulses on clk_sys
`include "tpl_defs.svh"
module tpl_channel #(
    parameter int POS_W = 32,
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // configuration byte of this channel
    input  wire logic [7:0]       ctl,
    // events and position
    input  wire logic             rise,
    input  wire logic             fall,
    input  wire logic [POS_W-1:0] position,
    // results
    output logic                  active,
    output logic                  rise_done,
    output logic                  fall_done,
    output logic                  trig_flag,
    output logic [POS_W-1:0]      rise_pos,
    output logic [POS_W-1:0]      fall_pos,
    output logic [CNT_W-1:0]      rise_cnt,
    output logic [CNT_W-1:0]      fall_cnt
);
    tpl_pkg::tpl_state_t state_q;
    tpl_pkg::tpl_mode_t  mode_q;
    logic                en_last_q;
    logic                rise_en_q;
    logic                fall_en_q;
    logic                arm;
    logic                take_rise;
    logic                take_fall;

    assign arm       = ctl[`TPL_CTL_ENABLE] & ~en_last_q;
    // enable is looked at directly so the cycle after a disable write takes nothing
    assign take_rise = (state_q == tpl_pkg::TPL_ARMED) & ctl[`TPL_CTL_ENABLE] & rise_en_q & rise;
    assign take_fall = (state_q == tpl_pkg::TPL_ARMED) & ctl[`TPL_CTL_ENABLE] & fall_en_q & fall;

    ////////////////////////////////////////////////////////////////////////////
    // arming
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_last_q <= 1'b0;
            state_q   <= tpl_pkg::TPL_IDLE;
            mode_q    <= tpl_pkg::TPL_SINGLE;
            rise_en_q <= 1'b0;
            fall_en_q <= 1'b0;
        end else begin
            en_last_q <= ctl[`TPL_CTL_ENABLE];
            if (!ctl[`TPL_CTL_ENABLE]) begin
                state_q <= tpl_pkg::TPL_IDLE;
            end else if (arm) begin
                // settings are caught only here, later edits wait for a re-arm
                state_q   <= tpl_pkg::TPL_ARMED;
                mode_q    <= tpl_pkg::tpl_mode_t'(ctl[`TPL_CTL_MODE]);
                rise_en_q <= ctl[`TPL_CTL_RISE];
                fall_en_q <= ctl[`TPL_CTL_FALL];
            end else begin
                case (state_q)
                    tpl_pkg::TPL_ARMED: begin
                        if ((take_rise | take_fall) && mode_q == tpl_pkg::TPL_SINGLE) begin
                            state_q <= tpl_pkg::TPL_SPENT;
                        end
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion flags, cleared on arming
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rise_done <= 1'b0;
            fall_done <= 1'b0;
            trig_flag <= 1'b0;
        end else if (arm) begin
            rise_done <= 1'b0;
            fall_done <= 1'b0;
            trig_flag <= 1'b0;
        end else begin
            rise_done <= rise_done | take_rise;
            fall_done <= fall_done | take_fall;
            trig_flag <= trig_flag | take_rise | take_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latches and counters
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rise_pos <= '0;
            fall_pos <= '0;
        end else begin
            if (take_rise) begin
                rise_pos <= position;
            end
            if (take_fall) begin
                fall_pos <= position;
            end
        end
    end

    // counters run only in continuous mode; they wrap rather than saturate
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rise_cnt <= '0;
            fall_cnt <= '0;
        end else if (mode_q == tpl_pkg::TPL_CONTINUOUS) begin
            if (take_rise) begin
                rise_cnt <= rise_cnt + 1'b1;
            end
            if (take_fall) begin
                fall_cnt <= fall_cnt + 1'b1;
            end
        end
    end

    assign active = (state_q != tpl_pkg::TPL_IDLE);

    AST_ARM_CLEARS: assert property (@(posedge clk_sys) disable iff (!resetn)
        arm |=> !rise_done && !fall_done && !trig_flag)
        else $error("flags not cleared on arming");
    AST_SINGLE_ONCE: assert property (@(posedge clk_sys) disable iff (!resetn)
        ((take_rise || take_fall) && mode_q == tpl_pkg::TPL_SINGLE && !arm) |=> state_q == tpl_pkg::TPL_SPENT)
        else $error("single mode did not stop after capture");
    AST_LATCH: assert property (@(posedge clk_sys) disable iff (!resetn)
        take_fall |=> fall_pos == $past(position))
        else $error("falling latch missed position");
    AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
        !ctl[`TPL_CTL_ENABLE] |=> $stable(rise_pos) && $stable(rise_cnt))
        else $error("disabled channel changed state");
    AST_CNT: assert property (@(posedge clk_sys) disable iff (!resetn)
        (take_rise && mode_q == tpl_pkg::TPL_CONTINUOUS) |=> rise_cnt == $past(rise_cnt) + 1'b1)
        else $error("rise counter did not step");
endmodule

// ---- verification/tpl_probe_sensor.sv ----
// probe sensor model: two switch outputs wired to the probe pins
// assumes the bench calls set_pins from a single process, off the rising edge of clk_sys
module tpl_probe_sensor (
    // clock
    input  wire logic clk_sys,
    // sensor outputs, push-pull, always driven
    output logic      pin_one,
    output logic      pin_two
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pin_one = 1'b0;
        pin_two = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // both outputs switch in one time step so a coincident pulse is truly coincident
    // settle gives the synchroniser and latch time before the bench looks
    task automatic set_pins(input logic one, input logic two, input int settle);
        @(negedge clk_sys);
        pin_one = one;
        pin_two = two;
        repeat (settle) @(negedge clk_sys);
    endtask
endmodule

// ---- verification/tb.sv ----
// testbench of the position capture unit: dictionary reads and writes against probe events
// assumes the sensor model drives the pins and the bench plays the fieldbus master
`include "tpl_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys;
    logic        resetn;
    logic        first_digital_input;
    logic        second_digital_input;
    logic [31:0] position;
    logic        obj_wr;
    logic        obj_rd;
    logic [15:0] obj_index;
    logic [7:0]  obj_sub;
    logic [31:0] obj_wdata;
    logic [31:0] obj_rdata;
    logic        obj_ack;
    logic        obj_err;
    int          err_count;
    int          num_checks;

    tpl_touch_probe #(.POS_W(32), .CNT_W(16)) dut (
        .clk_sys              (clk_sys),
        .resetn               (resetn),
        .first_digital_input  (first_digital_input),
        .second_digital_input (second_digital_input),
        .position             (position),
        .obj_wr               (obj_wr),
        .obj_rd               (obj_rd),
        .obj_index            (obj_index),
        .obj_sub              (obj_sub),
        .obj_wdata            (obj_wdata),
        .obj_rdata            (obj_rdata),
        .obj_ack              (obj_ack),
        .obj_err              (obj_err)
    );

    tpl_probe_sensor sensor (
        .clk_sys (clk_sys),
        .pin_one (first_digital_input),
        .pin_two (second_digital_input)
    );

    always #5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one strobe, answer sampled in the cycle after the taking edge, where it stands
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, input logic exp_err, output logic [31:0] rdata);
        @(negedge clk_sys);
        obj_wr    = wr;
        obj_rd    = !wr;
        obj_index = idx;
        obj_sub   = sub;
        obj_wdata = wd;
        @(negedge clk_sys);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        rdata  = obj_rdata;
        check({31'h0000_0000, obj_ack}, 32'h0000_0001);
        check({31'h0000_0000, obj_err}, {31'h0000_0000, exp_err});
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] val);
        logic [31:0] unused;
        access(1'b1, idx, sub, val, 1'b0, unused);
    endtask

    task automatic rdm(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] v;
        access(1'b0, idx, 8'h00, 32'h0000_0000, 1'b0, v);
        check(v & mask, exp);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        rdm(idx, 32'hffff_ffff, exp);
    endtask

    // position held steady across the latch so the expected value is exact
    task automatic ev(input logic one, input logic two, input logic [31:0] pos);
        position = pos;
        sensor.set_pins(one, two, 6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: no scenario needs anywhere near this many cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end

    initial begin
        logic [15:0] idx_list [9];
        logic [31:0] v;
        idx_list = '{`TPL_IDX_STATUS, `TPL_IDX_ONE_RISE_POS, `TPL_IDX_ONE_FALL_POS,
                     `TPL_IDX_TWO_RISE_POS, `TPL_IDX_TWO_FALL_POS, `TPL_IDX_ONE_RISE_CNT,
                     `TPL_IDX_ONE_FALL_CNT, `TPL_IDX_TWO_RISE_CNT, `TPL_IDX_TWO_FALL_CNT};
        clk_sys    = 1'b0;
        resetn     = 1'b0;
        position   = 32'h0000_0000;
        obj_wr     = 1'b0;
        obj_rd     = 1'b0;
        obj_index  = 16'h0000;
        obj_sub    = 8'h00;
        obj_wdata  = 32'h0000_0000;
        err_count  = 0;
        num_checks = 0;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        // reset contents, read-only write ignored, unknown index refused
        foreach (idx_list[i]) rd(idx_list[i], 32'h0000_0000);
        rd(`TPL_IDX_CONTROL, 32'h0000_0000);
        wr(`TPL_IDX_STATUS, 8'h00, 32'h0000_ffff);
        rd(`TPL_IDX_STATUS, 32'h0000_0000);
        access(1'b0, 16'h1234, 8'h00, 32'h0000_0000, 1'b1, v);
        check(v, 32'h0000_0000);
        // route pin one to channel one, pin two to channel two
        wr(`TPL_IDX_PIN_FUNC_ONE, 8'h01, 32'h0000_0020);
        wr(`TPL_IDX_PIN_FUNC_ONE, 8'h02, 32'h0000_0040);
        // channel one single shot on rising edges: second rise is not taken
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_0011);
        rd(`TPL_IDX_STATUS, 32'h0000_0001);
        ev(1'b1, 1'b0, 32'h1111_0001);
        rd(`TPL_IDX_STATUS, 32'h0000_0003);
        rd(`TPL_IDX_ONE_RISE_POS, 32'h1111_0001);
        rdm(`TPL_IDX_INPUT_STATUS, 32'h0c00_0000, 32'h0400_0000);
        ev(1'b0, 1'b0, 32'h1111_0002);
        ev(1'b1, 1'b0, 32'h1111_0003);
        rd(`TPL_IDX_ONE_RISE_POS, 32'h1111_0001);
        rd(`TPL_IDX_ONE_FALL_POS, 32'h0000_0000);
        rd(`TPL_IDX_ONE_RISE_CNT, 32'h0000_0000);
        // disabled channel ignores edges
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_0000);
        rd(`TPL_IDX_STATUS, 32'h0000_0002);
        ev(1'b0, 1'b0, 32'h2222_0001);
        ev(1'b1, 1'b0, 32'h2222_0002);
        rd(`TPL_IDX_ONE_RISE_POS, 32'h1111_0001);
        // re-arm single shot on falling edges: flags cleared first
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_0021);
        rd(`TPL_IDX_STATUS, 32'h0000_0001);
        rdm(`TPL_IDX_INPUT_STATUS, 32'h0400_0000, 32'h0000_0000);
        ev(1'b0, 1'b0, 32'hffff_fff0);
        rd(`TPL_IDX_STATUS, 32'h0000_0005);
        rd(`TPL_IDX_ONE_FALL_POS, 32'hffff_fff0);
        rd(`TPL_IDX_ONE_RISE_POS, 32'h1111_0001);
        rd(`TPL_IDX_ONE_FALL_CNT, 32'h0000_0000);
        // channel two continuous on both edges, latch keeps the latest
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_0000);
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_3300);
        rd(`TPL_IDX_STATUS, 32'h0000_0104);
        ev(1'b0, 1'b1, 32'h3333_0001);
        ev(1'b0, 1'b0, 32'h3333_0002);
        ev(1'b0, 1'b1, 32'h3333_0003);
        ev(1'b0, 1'b0, 32'h3333_0004);
        rd(`TPL_IDX_STATUS, 32'h0000_0704);
        rd(`TPL_IDX_TWO_RISE_POS, 32'h3333_0003);
        rd(`TPL_IDX_TWO_FALL_POS, 32'h3333_0004);
        rd(`TPL_IDX_TWO_RISE_CNT, 32'h0000_0002);
        rd(`TPL_IDX_TWO_FALL_CNT, 32'h0000_0002);
        rdm(`TPL_IDX_INPUT_STATUS, 32'h0800_0000, 32'h0800_0000);
        rd(`TPL_IDX_ONE_RISE_CNT, 32'h0000_0000);
        // both pins on channel one, continuous rise: coincident edges count once
        wr(`TPL_IDX_PIN_FUNC_ONE, 8'h02, 32'h0000_0020);
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_0000);
        wr(`TPL_IDX_CONTROL, 8'h00, 32'h0000_0013);
        ev(1'b1, 1'b1, 32'h4444_0001);
        rd(`TPL_IDX_ONE_RISE_CNT, 32'h0000_0001);
        ev(1'b0, 1'b0, 32'h4444_0002);
        ev(1'b1, 1'b0, 32'h4444_0003);
        ev(1'b1, 1'b1, 32'h4444_0004);
        rd(`TPL_IDX_ONE_RISE_CNT, 32'h0000_0003);
        rd(`TPL_IDX_ONE_RISE_POS, 32'h4444_0004);
        rd(`TPL_IDX_ONE_FALL_CNT, 32'h0000_0000);
        rd(`TPL_IDX_TWO_RISE_CNT, 32'h0000_0002);
        rd(`TPL_IDX_STATUS, 32'h0000_0603);
        stop_test();
    end
endmodule
